// ==== hdl/pit_pkg.sv ====
// Constants and types shared by the three-channel interval timer.
package pit_pkg;
  localparam int         NCH       = 3;
  localparam int         CW        = 16;
  localparam int         AW        = 5;
  localparam int         DW        = 32;
  // Register indices; the byte address is four times the index.
  localparam logic [2:0] IDX_CNT0  = 3'h4;
  localparam logic [2:0] IDX_CNT1  = 3'h5;
  localparam logic [2:0] IDX_CNT2  = 3'h6;
  localparam logic [2:0] IDX_CTL   = 3'h7;
  // Control word layout.
  localparam int         SEL_POS   = 6;
  localparam int         ACC_POS   = 4;
  localparam int         MODE_POS  = 1;
  localparam int         BCD_POS   = 0;
  localparam logic [1:0] SEL_BAD   = 2'h3;
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LO    = 2'h1;
  localparam logic [1:0] ACC_HI    = 2'h2;
  localparam logic [1:0] ACC_BOTH  = 2'h3;
  // Counting modes.
  localparam logic [2:0] M_EVT     = 3'h0;
  localparam logic [2:0] M_ONE     = 3'h1;
  localparam logic [2:0] M_RATE    = 3'h2;
  localparam logic [2:0] M_SQR     = 3'h3;
  localparam logic [2:0] M_SWS     = 3'h4;
  localparam logic [2:0] M_HWS     = 3'h5;
  localparam logic [CW-1:0] ONE    = 16'h0001;
  localparam logic [DW-1:0] RD_NONE = 32'h0000_0000;

  typedef struct packed {
    logic          read;
    logic          write;
    logic [AW-1:0] address;
    logic [DW-1:0] writedata;
  } pit_avs_req_t;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [CW-1:0] rld;
    logic [CW-1:0] hold;
    logic [7:0]    lo;
    logic [2:0]    mode;
    logic [1:0]    acc;
    logic          bcd;
    logic          latched;
    logic          wr_hi;
    logic          rd_hi;
    logic          armed;
    logic          out;
    logic          gate_q;
    logic          clk_q;
    logic          trig;
  } pit_ch_t;

  typedef struct packed {
    pit_ch_t [NCH-1:0] ch;
    logic [7:0]        div;
    logic              ack;
    logic [DW-1:0]     rdata;
  } pit_state_t;
endpackage

// ==== hdl/pit_timer.sv ====
// Three-channel 16-bit interval timer with an Avalon-MM register slave.
//
// Operation
// - Three independent 16-bit presettable down counters.
// - Load values up to 65,535 accepted.
// - Counter 2 clocked at bus clock divided by CH2_DIV.
// - Counters 0 and 1 use external clock, gate.
// - Gate rising edge triggers; clock rising counts.
// - Event mode: load drives low, zero drives high.
// - Event mode counts only while gate enables.
// - One-shot: low after trigger until zero.
// - One-shot retrigger reloads and restarts pulse.
// - Rate mode: one-clock low every N counts.
// - Rate mode runs while gate high, stops low.
// - Square wave: high (N+1)/2, low (N-1)/2 for odd N; N/2 each for even N.
// - Square wave steps by two, reload per half.
// - Software strobe: count on write, one-clock low.
// - Host rewrites for another strobe; gate low holds.
// - Hardware strobe: gate edge starts, one-clock low.
// - Strobe only after full count since edge.
// - Control word selects counter, access, mode, BCD.
// - Latch command copies count into hold register.
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pit_timer #(
  parameter int CH2_DIV = 2
) (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire pit_pkg::pit_avs_req_t avs_req,
  output logic [pit_pkg::DW-1:0]     avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [1:0]            ext_clk,
  input  wire logic [pit_pkg::NCH-1:0] gate,
  output logic [pit_pkg::NCH-1:0]    tmr_out
);
  import pit_pkg::*;

  if (CH2_DIV < 2 || CH2_DIV > 256)
  begin : g_chk
    $error("CH2_DIV must lie between 2 and 256.");
  end

  pit_state_t    q;
  pit_state_t    d;
  logic          req_act;
  logic [2:0]    idx;
  logic [1:0]    k;
  logic [7:0]    wb;
  logic [CW-1:0] lv;
  logic [CW-1:0] src;
  logic [CW-1:0] dn1;
  logic [CW-1:0] dn2;
  logic          lgo;
  logic [NCH-1:0] cin;
  logic [NCH-1:0] tk;
  logic [NCH-1:0] ld;
  logic [NCH-1:0] ltc;

  // Decrement by one in binary or in four BCD digits.
  function automatic logic [CW-1:0] dec1(input logic [CW-1:0] v, input logic bcd);
    logic [CW-1:0] r;
    logic          br;
    r  = v;
    br = 1'b1;
    if (!bcd)
    begin
      r = v - ONE;
    end
    else
    begin
      for (int j = 0; j < 4; j++)
      begin
        if (br)
        begin
          if (r[4*j +: 4] == 4'h0)
          begin
            r[4*j +: 4] = 4'h9;
          end
          else
          begin
            r[4*j +: 4] = r[4*j +: 4] - 4'h1;
            br          = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  assign req_act         = (avs_req.read | avs_req.write) & ~q.ack;
  assign avs_waitrequest = req_act;
  assign avs_readdata    = q.rdata;
  assign idx             = avs_req.address[AW-1:2];
  assign wb              = avs_req.writedata[7:0];
  // Counter 2 has no pin clock; its count event comes from the divider.
  assign cin             = {1'b0, ext_clk};

  always_comb
  begin
    d     = q;
    tk    = '0;
    ld    = '0;
    ltc   = '0;
    k     = '0;
    lv    = '0;
    src   = '0;
    dn1   = '0;
    dn2   = '0;
    lgo   = 1'b0;
    d.ack = req_act;
    d.div = (q.div == 8'(CH2_DIV - 1)) ? 8'h00 : q.div + 8'h01;
    for (int i = 0; i < NCH; i++)
    begin
      tk[i] = (i == 2) ? (q.div == 8'h00) : (cin[i] & ~q.ch[i].clk_q);
      d.ch[i].clk_q  = cin[i];
      d.ch[i].gate_q = gate[i];
      dn1 = dec1(q.ch[i].cnt, q.ch[i].bcd);
      dn2 = dec1(dn1, q.ch[i].bcd);
      // A trigger waits for the next count event; a new edge is never lost.
      d.ch[i].trig = (q.ch[i].trig & ~tk[i]) | (gate[i] & ~q.ch[i].gate_q);
      if (tk[i])
      begin
        unique case (q.ch[i].mode)
          M_EVT:
          begin
            if (q.ch[i].armed && gate[i])
            begin
              d.ch[i].cnt = dn1;
              if (q.ch[i].cnt == ONE)
              begin
                d.ch[i].out   = 1'b1;
                d.ch[i].armed = 1'b0;
              end
            end
          end
          M_ONE, M_HWS:
          begin
            if (q.ch[i].trig)
            begin
              d.ch[i].cnt   = q.ch[i].rld;
              d.ch[i].armed = 1'b1;
              d.ch[i].out   = (q.ch[i].mode == M_HWS);
            end
            else if (q.ch[i].armed)
            begin
              d.ch[i].cnt = dn1;
              d.ch[i].out = (q.ch[i].mode == M_ONE) ? q.ch[i].out : 1'b1;
              if (q.ch[i].cnt == ONE)
              begin
                d.ch[i].armed = 1'b0;
                d.ch[i].out   = (q.ch[i].mode == M_ONE);
              end
            end
            else
            begin
              d.ch[i].out = 1'b1;
            end
          end
          M_RATE:
          begin
            if (q.ch[i].armed && gate[i])
            begin
              d.ch[i].out = 1'b1;
              if (q.ch[i].trig || q.ch[i].cnt == ONE)
              begin
                d.ch[i].cnt = q.ch[i].rld;
                d.ch[i].out = q.ch[i].trig;
              end
              else
              begin
                d.ch[i].cnt = dn1;
              end
            end
          end
          M_SQR:
          begin
            // An odd count spends one extra event at zero in the high half.
            if (q.ch[i].armed && gate[i])
            begin
              if (q.ch[i].trig)
              begin
                d.ch[i].cnt = {q.ch[i].rld[CW-1:1], 1'b0};
                d.ch[i].out = 1'b1;
              end
              else if (q.ch[i].cnt == '0 ||
                       (dn2 == '0 && !(q.ch[i].out && q.ch[i].rld[0])))
              begin
                d.ch[i].out = ~q.ch[i].out;
                d.ch[i].cnt = {q.ch[i].rld[CW-1:1], 1'b0};
              end
              else
              begin
                d.ch[i].cnt = dn2;
              end
            end
          end
          M_SWS:
          begin
            d.ch[i].out = 1'b1;
            if (q.ch[i].armed && gate[i])
            begin
              d.ch[i].cnt = dn1;
              if (q.ch[i].cnt == ONE)
              begin
                d.ch[i].out   = 1'b0;
                d.ch[i].armed = 1'b0;
              end
            end
          end
          default:
          begin
            d.ch[i].out = 1'b1;
          end
        endcase
      end
      if ((q.ch[i].mode == M_RATE || q.ch[i].mode == M_SQR) && !gate[i])
      begin
        d.ch[i].out = 1'b1;
      end
    end
    if (req_act && idx >= IDX_CNT0)
    begin
      if (idx == IDX_CTL)
      begin
        k = wb[SEL_POS +: 2];
        if (avs_req.write && k != SEL_BAD)
        begin
          if (wb[ACC_POS +: 2] == ACC_LATCH)
          begin
            ltc[k] = 1'b1;
            if (!q.ch[k].latched)
            begin
              d.ch[k].hold    = q.ch[k].cnt;
              d.ch[k].latched = 1'b1;
            end
          end
          else
          begin
            d.ch[k].acc     = wb[ACC_POS +: 2];
            d.ch[k].mode    = wb[MODE_POS + 1] ? {1'b0, wb[MODE_POS +: 2]}
                                               : wb[MODE_POS +: 3];
            d.ch[k].bcd     = wb[BCD_POS];
            d.ch[k].out     = (d.ch[k].mode != M_EVT);
            d.ch[k].armed   = 1'b0;
            d.ch[k].wr_hi   = 1'b0;
            d.ch[k].rd_hi   = 1'b0;
            d.ch[k].latched = 1'b0;
          end
        end
        d.rdata = RD_NONE;
      end
      else
      begin
        k = 2'(idx - IDX_CNT0);
        if (avs_req.write)
        begin
          unique case (q.ch[k].acc)
            ACC_LO:    lv = {8'h00, wb};
            ACC_HI:    lv = {wb, 8'h00};
            default:   lv = {wb, q.ch[k].lo};
          endcase
          lgo = (q.ch[k].acc != ACC_BOTH) || q.ch[k].wr_hi;
          d.ch[k].lo    = wb;
          d.ch[k].wr_hi = (q.ch[k].acc == ACC_BOTH) && !q.ch[k].wr_hi;
          if (lgo)
          begin
            ld[k]         = 1'b1;
            d.ch[k].rld   = lv;
            d.ch[k].armed = (q.ch[k].mode != M_ONE && q.ch[k].mode != M_HWS);
            d.ch[k].out   = (q.ch[k].mode != M_EVT);
            if (q.ch[k].mode == M_SQR)
            begin
              d.ch[k].cnt = {lv[CW-1:1], 1'b0};
            end
            else if (q.ch[k].mode != M_ONE && q.ch[k].mode != M_HWS)
            begin
              d.ch[k].cnt = lv;
            end
          end
          d.rdata = RD_NONE;
        end
        else
        begin
          src = q.ch[k].latched ? q.ch[k].hold : q.ch[k].cnt;
          if (q.ch[k].acc == ACC_HI || (q.ch[k].acc == ACC_BOTH && q.ch[k].rd_hi))
          begin
            d.rdata = {24'h000000, src[15:8]};
          end
          else
          begin
            d.rdata = {24'h000000, src[7:0]};
          end
          d.ch[k].rd_hi = (q.ch[k].acc == ACC_BOTH) && !q.ch[k].rd_hi;
          if (q.ch[k].acc != ACC_BOTH || q.ch[k].rd_hi)
          begin
            d.ch[k].latched = 1'b0;
          end
        end
      end
    end
    else if (req_act)
    begin
      d.rdata = RD_NONE;
    end
  end

  // Clock enable low freezes every flip-flop, the bus answer included.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end

  for (genvar g = 0; g < NCH; g++)
  begin : g_out
    assign tmr_out[g] = q.ch[g].out;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rate_low;
    !tmr_out[0] && q.ch[0].cnt == q.ch[0].rld;
  endsequence

  sequence s_strobe_end;
    !tmr_out[0] ##1 (!tk[0] || !clk_en)[*1] ##0 !tmr_out[0];
  endsequence

  AST_BUS_ANSWER: assert property (
    (avs_waitrequest && clk_en) |=> !avs_waitrequest)
    else $error("Bus request not answered after one wait cycle.");
  AST_CH2_HALF: assert property (
    (clk_en && tk[2]) |=> !tk[2])
    else $error("Counter 2 count event faster than half clock.");
  AST_EVT_LOAD: assert property (
    (clk_en && ld[0] && q.ch[0].mode == M_EVT) |=> !tmr_out[0] && q.ch[0].armed)
    else $error("Event mode load did not drive output low.");
  AST_EVT_DONE: assert property (
    (clk_en && tk[0] && gate[0] && q.ch[0].mode == M_EVT && q.ch[0].armed &&
     q.ch[0].cnt == ONE && !req_act) |=> tmr_out[0] && q.ch[0].cnt == '0)
    else $error("Event mode output did not rise at zero.");
  AST_EVT_HOLD: assert property (
    (q.ch[0].mode == M_EVT && !gate[0] && !req_act) |=> $stable(q.ch[0].cnt))
    else $error("Event mode counted with gate low.");
  AST_ONE_TRIG: assert property (
    (clk_en && tk[0] && q.ch[0].trig && q.ch[0].mode == M_ONE && !req_act)
    |=> !tmr_out[0] && q.ch[0].cnt == q.ch[0].rld)
    else $error("One-shot trigger did not reload and drive low.");
  AST_RATE_PULSE: assert property (
    (clk_en && tk[0] && gate[0] && q.ch[0].mode == M_RATE && q.ch[0].armed &&
     !q.ch[0].trig && q.ch[0].cnt == ONE && !req_act) |=> s_rate_low)
    else $error("Rate mode did not pulse low and reload.");
  AST_RATE_GATE: assert property (
    (clk_en && q.ch[0].mode == M_RATE && !gate[0] && !req_act) |=> tmr_out[0])
    else $error("Rate mode output not high with gate low.");
  AST_SWS_STROBE: assert property (
    (clk_en && tk[0] && !tmr_out[0] && q.ch[0].mode == M_SWS && !req_act)
    |=> tmr_out[0])
    else $error("Software strobe lasted longer than one count.");
  AST_SWS_STOP: assert property (
    (q.ch[0].mode == M_SWS && !tmr_out[0]) |-> !q.ch[0].armed)
    else $error("Software strobe rearmed without a new load.");
  AST_LATCH: assert property (
    (clk_en && ltc[0] && !q.ch[0].latched)
    |=> q.ch[0].latched && q.ch[0].hold == $past(q.ch[0].cnt))
    else $error("Latch command did not capture the count.");
  AST_TWO_BYTE: assert property (
    (clk_en && req_act && avs_req.write && idx == IDX_CNT0 &&
     q.ch[0].acc == ACC_BOTH && !q.ch[0].wr_hi) |=> !$past(ld[0]) && q.ch[0].wr_hi)
    else $error("Two-byte load took effect after the low byte.");
endmodule

// ==== sim/pit_ext.sv ====
// Far-side model that makes the external count clocks of counters 0 and 1.
`timescale 1ns/1ps
module pit_ext (
  input  wire logic       ref_clk,
  input  wire logic [1:0] run,
  output logic [1:0]      ext_clk = 2'h0
);
  logic [1:0] ph_q = 2'h0;

  // The clock rests low between bursts so that no stray count event reaches a counter.
  always @(posedge ref_clk)
  begin
    ph_q    <= ph_q + 2'h1;
    ext_clk <= run & {2{ph_q[1]}};
  end
endmodule

// ==== sim/pit_timer_tb.sv ====
// Self-checking testbench for the three-channel interval timer.
`timescale 1ns/1ps
module pit_timer_tb;
  import pit_pkg::*;
  typedef struct packed {
    logic [1:0]  ch;
    logic [2:0]  mode;
    logic [15:0] n;
    logic [1:0]  g;
    logic [7:0]  k;
    logic        ex;
  } pit_row_t;
  localparam int  D2 = 4;
  logic           ref_clk;
  logic           sys_rst;
  logic           clk_en;
  pit_avs_req_t   req;
  logic [DW-1:0]  rdata;
  logic           waitreq;
  logic [1:0]     run;
  logic [1:0]     ext_clk;
  logic [NCH-1:0] gate;
  logic [NCH-1:0] tmr_out;
  logic [7:0]     q;
  logic [15:0]    seen_o;
  logic [15:0]    exp_o;
  logic           sel_clk;
  int             sel;
  int             err_total;
  int             total_checks;
  int             c;
  pit_row_t       rows [23];

  assign sel_clk = ext_clk[sel[0]];

  pit_timer #(.CH2_DIV(D2)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .avs_req(req),
    .avs_readdata(rdata), .avs_waitrequest(waitreq), .ext_clk(ext_clk),
    .gate(gate), .tmr_out(tmr_out));
  pit_ext u_ext (.ref_clk(ref_clk), .run(run), .ext_clk(ext_clk));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // The request stands until waitrequest is sampled low, then drops at that same edge.
  // Only the watchdog ends a wait that never gets its answer.
  task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: {24'h0, d}};
    do
    begin
      @(posedge ref_clk);
    end while (waitreq !== 1'b0);
    q = rdata[7:0];
    req <= '0;
  endtask

  task automatic prog(input logic [1:0] ch, input logic [2:0] m, input logic [15:0] n);
    bus(1'b1, IDX_CTL, {ch, ACC_BOTH, m, 1'b0});
    bus(1'b1, IDX_CNT0 + 3'(ch), n[7:0]);
    bus(1'b1, IDX_CNT0 + 3'(ch), n[15:8]);
  endtask

  // Bursts of count events; the output is sampled once it has had time to settle.
  task automatic ev(input int ch, input int k);
    sel = ch;
    @(posedge ref_clk);
    run[ch] <= 1'b1;
    repeat (k) @(posedge sel_clk);
    @(posedge ref_clk);
    run[ch] <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask

  task automatic rdback(input logic [1:0] ch, input logic [15:0] n);
    @(posedge ref_clk);
    gate[ch] <= 1'b0;
    prog(ch, M_SWS, n);
    bus(1'b1, IDX_CTL, {ch, ACC_LATCH, 4'h0});
    bus(1'b0, IDX_CNT0 + 3'(ch), 8'h00);
    chk("held low byte", 16'(q), 16'(n[7:0]));
    bus(1'b0, IDX_CNT0 + 3'(ch), 8'h00);
    chk("held high byte", 16'(q), 16'(n[15:8]));
    bus(1'b0, IDX_CNT0 + 3'(ch), 8'h00);
    chk("direct low byte", 16'(q), 16'(n[7:0]));
    $display("readback test done");
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    wrap_up();
  end

  initial
  begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    req = '0;
    run = 2'h0;
    gate = 3'h0;
    sel = 0;
    err_total = 0;
    total_checks = 0;
    rows = '{
      '{2'h0, M_EVT, 16'h3, 2'h1, 8'h2, 1'h0}, '{2'h0, M_EVT, 16'h3, 2'h1, 8'h3, 1'h1},
      '{2'h1, M_EVT, 16'h3, 2'h0, 8'h5, 1'h0}, '{2'h1, M_EVT, 16'h3, 2'h2, 8'h3, 1'h1},
      '{2'h0, M_ONE, 16'h3, 2'h2, 8'h1, 1'h0}, '{2'h1, M_ONE, 16'h3, 2'h2, 8'h4, 1'h1},
      '{2'h0, M_RATE, 16'h4, 2'h1, 8'h3, 1'h1}, '{2'h0, M_RATE, 16'h4, 2'h1, 8'h4, 1'h0},
      '{2'h0, M_RATE, 16'h4, 2'h1, 8'h5, 1'h1}, '{2'h1, M_RATE, 16'h4, 2'h1, 8'h8, 1'h0},
      '{2'h0, M_RATE, 16'h4, 2'h0, 8'h8, 1'h1}, '{2'h0, M_SQR, 16'h5, 2'h1, 8'h2, 1'h1},
      '{2'h0, M_SQR, 16'h5, 2'h1, 8'h3, 1'h0}, '{2'h0, M_SQR, 16'h5, 2'h1, 8'h4, 1'h0},
      '{2'h1, M_SQR, 16'h5, 2'h1, 8'h5, 1'h1}, '{2'h0, M_SWS, 16'h3, 2'h1, 8'h2, 1'h1},
      '{2'h0, M_SWS, 16'h3, 2'h1, 8'h3, 1'h0}, '{2'h0, M_SWS, 16'h3, 2'h1, 8'h4, 1'h1},
      '{2'h1, M_SWS, 16'h3, 2'h1, 8'h9, 1'h1}, '{2'h0, M_SWS, 16'h3, 2'h0, 8'h9, 1'h1},
      '{2'h0, M_HWS, 16'h3, 2'h2, 8'h3, 1'h1}, '{2'h1, M_HWS, 16'h3, 2'h2, 8'h4, 1'h0},
      '{2'h0, M_HWS, 16'h3, 2'h2, 8'h5, 1'h1}};
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk("reset outputs", 16'(tmr_out), 16'h0000);
    chk("reset readdata", rdata[15:0], 16'h0000);
    chk("reset waitrequest", 16'(waitreq), 16'h0000);
    $display("reset test done");
    foreach (rows[i])
    begin
      @(posedge ref_clk);
      gate[rows[i].ch] <= (rows[i].g == 2'h1);
      prog(rows[i].ch, rows[i].mode, rows[i].n);
      if (rows[i].g == 2'h2)
      begin
        repeat (3) @(posedge ref_clk);
        gate[rows[i].ch] <= 1'b1;
      end
      ev(int'(rows[i].ch), int'(rows[i].k));
      seen_o = 16'(tmr_out[rows[i].ch]);
      exp_o  = 16'(rows[i].ex);
      case (rows[i].mode)
        M_EVT:   chk("event output", seen_o, exp_o);
        M_ONE:   chk("one-shot output", seen_o, exp_o);
        M_RATE:  chk("rate output", seen_o, exp_o);
        M_SQR:   chk("square output", seen_o, exp_o);
        M_SWS:   chk("soft strobe output", seen_o, exp_o);
        default: chk("hard strobe output", seen_o, exp_o);
      endcase
      $display("row %0d done", i);
    end
    rdback(2'h0, 16'h1234);
    rdback(2'h1, 16'hFFFF);
    rdback(2'h2, 16'h0001);
    bus(1'b1, IDX_CTL, {SEL_BAD, ACC_LATCH, 4'h0});
    bus(1'b0, 3'h1, 8'h00);
    chk("unmapped read", 16'(q), 16'h0000);
    bus(1'b0, IDX_CTL, 8'h00);
    chk("control read", 16'(q), 16'h0000);
    $display("refusal test done");
    // Retrigger halfway through the one-shot so the pulse must stretch.
    @(posedge ref_clk);
    gate[0] <= 1'b0;
    prog(2'h0, M_ONE, 16'h0003);
    repeat (3) @(posedge ref_clk);
    gate[0] <= 1'b1;
    ev(0, 2);
    gate[0] <= 1'b0;
    repeat (3) @(posedge ref_clk);
    gate[0] <= 1'b1;
    ev(0, 2);
    chk("retriggered pulse", 16'(tmr_out[0]), 16'h0000);
    ev(0, 2);
    chk("retriggered end", 16'(tmr_out[0]), 16'h0001);
    $display("retrigger test done");
    // Ten in BCD steps down to nine; a binary counter would show 0F.
    bus(1'b1, IDX_CTL, {2'h0, ACC_BOTH, M_SWS, 1'b1});
    bus(1'b1, IDX_CNT0, 8'h10);
    bus(1'b1, IDX_CNT0, 8'h00);
    ev(0, 1);
    bus(1'b1, IDX_CTL, {2'h0, ACC_LATCH, 4'h0});
    bus(1'b0, IDX_CNT0, 8'h00);
    chk("bcd low byte", 16'(q), 16'h0009);
    $display("bcd test done");
    @(posedge ref_clk);
    gate[2] <= 1'b1;
    prog(2'h2, M_SWS, 16'h000A);
    c = 0;
    while (tmr_out[2] !== 1'b0 && c < 200)
    begin
      @(posedge ref_clk);
      c++;
    end
    // Hold the strobe frozen with the clock enable low, then let it finish.
    clk_en <= 1'b0;
    chk("counter 2 delay", 16'(c > 9 * D2 && c <= 10 * D2), 16'h0001);
    $display("counter 2 test done");
    repeat (20) @(posedge ref_clk);
    chk("frozen strobe", 16'(tmr_out[2]), 16'h0000);
    clk_en <= 1'b1;
    repeat (D2 + 2) @(posedge ref_clk);
    chk("strobe after freeze", 16'(tmr_out[2]), 16'h0001);
    $display("clock enable test done");
    wrap_up();
  end
endmodule
